// file: src/iss_defs.svh
// constants for the status, steering and serial interrupt block
// assumes inclusion by bare name from the package and both ends
`ifndef ISS_DEFS_SVH
`define ISS_DEFS_SVH

// register offsets on the software port
`define ISS_A_CMD0      4'h0
`define ISS_A_MASK0     4'h1
`define ISS_A_CMD1      4'h2
`define ISS_A_MASK1     4'h3
`define ISS_A_ROUTE     4'h4
`define ISS_A_SCFG      4'h8

// command word fields
`define ISS_CW_KIND     4:3
`define ISS_KIND_EOS    2'h0
`define ISS_KIND_THIRD  2'h1
`define ISS_CW_EOS      5
`define ISS_CW_SET_SPECIAL_MASK_FLAG     6
`define ISS_CW_SMM      5
`define ISS_CW_POLL     2
`define ISS_CW_RR       1
`define ISS_CW_RIS      0

// route control and serial configuration fields
`define ISS_RT_DIS      7
`define ISS_RT_TGT      3:0
`define ISS_SCFG_QUIET  0
`define ISS_SCFG_LEN    3:1

// reset values
`define ISS_RT_RST      8'h80
`define ISS_MASK_RST    8'h00
`define ISS_SCFG_RST    8'h06

// level sets: steering targets and serially reported levels
`define ISS_STEER_OK    16'hDEF8
`define ISS_SER_IRQ_OK  16'hDEFA

// serial line frame numbers, timing in clocks and the spurious level
`define ISS_SIRQ_FRAMES 21
`define ISS_FR_MGMT     3
`define ISS_FR_CHK      17
`define ISS_FR_PCI      18
`define ISS_STOP_QUIET  4'h2
`define ISS_STOP_CONT   4'h3
`define ISS_IDLE_GAP    4'h2
`define ISS_LEN_MIN     3'h3
`define ISS_SPURIOUS    4'h7

`endif

// file: src/iss_pkg.sv
// types shared by both ends of the serial interrupt line
// assumes iss_defs.svh is on the include path
package iss_pkg;
`include "iss_defs.svh"

   // host side serial sequencer
   typedef enum logic [2:0] {
      HS_IDLE, HS_START, HS_RISE, HS_DATA, HS_STOP, HS_STOPHI
   } iss_hst_t;

   // peripheral side serial sequencer
   typedef enum logic [2:0] {
      PS_IDLE, PS_SELF, PS_WAIT, PS_DATA, PS_STOP
   } iss_pst_t;
endpackage

// file: src/iss_sirq_if.sv
// shared open-collector serial interrupt line between host and peripheral
// assumes a pull-up: the line is high unless some party drives it low
`timescale 1ns/10ps
interface iss_sirq_if;
   logic host_o;
   logic host_oe;
   logic per_o;
   logic per_oe;
   logic line;

   // wired level of the line with pull-up
   assign line = ~((host_oe & ~host_o) | (per_oe & ~per_o));

   modport host (output host_o, output host_oe, input line);
   modport per  (output per_o, output per_oe, input line);
endinterface

// file: src/iss_host.sv
// host end: status read path, special mask, pci steering, serial host
// assumes one clock, synchronous inputs except the pci lines
//
// Function
// - special mask: mask bit blocks only its level
// - third word set_special_mask_flag/smm sets or clears special mask
// - in-service level blocks lower levels otherwise
// - request register shows lines, ack clears top
// - service bit set on ack, cleared by eos
// - rr with ris picks request or service status
// - status selection persists across reads
// - poll wins over register read selection
// - selection defaults to request register
// - mask address reads the level mask
// - four pci lines route to eleven inputs
// - pci lines synchronised before the multiplexer
// - route bits 3:0 target, bit 7 disables
// - pci lines active low, level, shareable
// - peripheral restarts clock before signalling
// - peripheral starts quiet frame with one low
// - host extends peripheral start, then drives high
// - host starts frames in continuous mode, default
// - frames counted from rise, three phases each
// - peripheral drives only its active sample phase
// - host decodes frame n at clock 3n-1
// - frame three raises management interrupt output
// - stop frame two clocks quiet, three continuous
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "iss_defs.svh"
module iss_host
   import iss_pkg::*;
#(
   parameter int NFRAMES = `ISS_SIRQ_FRAMES
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   // software register port
   input  wire logic [3:0]   addr_in,
   input  wire logic [7:0]   wdata_in,
   input  wire logic         wr_in,
   input  wire logic         rd_in,
   output logic      [7:0]   rdata_out,
   // legacy requests and pci lines
   input  wire logic [15:0]  irq_in,
   input  wire logic [3:0]   pci_interrupt_line_n_in,
   // processor side
   input  wire logic         inta_in,
   output logic              intr_out,
   output logic      [3:0]   ack_level_out,
   output logic              external_mgmt_interrupt_out,
   output logic              channel_check_error_out,
   // serial interrupt line
   iss_sirq_if.host          sio
);
   if (NFRAMES < 21 || NFRAMES > 32) begin : g_chk
      $error("NFRAMES must lie in 21..32");
   end

   logic [15:0] mask_reg, irr_reg, isr_reg;
   logic [1:0]  smm_reg, ris_reg, poll_reg;
   logic [7:0]  route_reg [4];
   logic [7:0]  scfg_reg;
   logic [3:0]  pci_s1_reg, pci_s2_reg;
   logic [NFRAMES:1] ser_reg;
   iss_hst_t    hst_reg;
   logic [3:0]  cnt_reg;
   logic [1:0]  ph_reg;
   logic [5:0]  fr_reg;
   logic        quiet_reg, o_reg, oe_reg;
   logic [15:0] steer, raw_req, elig, eos_clr;
   logic [3:0]  pick;
   logic        any, bank, cmd_wr, cmd_rd, take;
   logic [7:0]  rd_mux;
   logic [2:0]  slen;

   assign bank   = addr_in[1];
   assign cmd_wr = wr_in && (addr_in == `ISS_A_CMD0 || addr_in == `ISS_A_CMD1);
   assign cmd_rd = rd_in && (addr_in == `ISS_A_CMD0 || addr_in == `ISS_A_CMD1);
   assign take   = (inta_in || (cmd_rd && poll_reg[bank])) && any;

   // start extension clamped to the shortest legal length
   assign slen = (scfg_reg[`ISS_SCFG_LEN] < `ISS_LEN_MIN) ? `ISS_LEN_MIN
                 : scfg_reg[`ISS_SCFG_LEN];

   // two-flop synchroniser on the pci lines
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pci_s1_reg <= 4'hF;
         pci_s2_reg <= 4'hF;
      end else begin
         pci_s1_reg <= pci_interrupt_line_n_in;
         pci_s2_reg <= pci_s1_reg;
      end
   end

   // steering multiplexer, shared targets are or-ed
   always_comb begin
      logic act;
      act   = 1'b0;
      steer = 16'h0000;
      for (int l = 0; l < 4; l++) begin
         act = ~pci_s2_reg[l] | ser_reg[`ISS_FR_PCI + l];
         if (act && !route_reg[l][`ISS_RT_DIS]) begin
            steer[route_reg[l][`ISS_RT_TGT]] = 1'b1;
         end
      end
      steer = steer & `ISS_STEER_OK;
   end

   assign raw_req = irq_in | steer | (ser_reg[16:1] & `ISS_SER_IRQ_OK);

   // priority resolution, level 0 highest
   always_comb begin
      logic blk;
      blk  = 1'b0;
      elig = 16'h0000;
      pick = `ISS_SPURIOUS;
      any  = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (isr_reg[i]) begin
            blk = 1'b1;
         end
         elig[i] = irr_reg[i] & ~mask_reg[i]
                   & (smm_reg[i / 8] | ~blk);
      end
      for (int i = 15; i >= 0; i--) begin
         if (elig[i]) begin
            pick = i[3:0];
            any  = 1'b1;
         end
      end
   end

   // top in-service bit of the addressed bank for eos
   always_comb begin
      logic found;
      found   = 1'b0;
      eos_clr = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (i[3] == bank && isr_reg[i] && !found) begin
            eos_clr[i] = 1'b1;
            found      = 1'b1;
         end
      end
   end

   // request and in-service registers, ack clear beats request, service set beats eos clear
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         irr_reg <= 16'h0000;
         isr_reg <= 16'h0000;
      end else begin
         irr_reg <= raw_req;
         if (take) begin
            irr_reg[pick] <= 1'b0;
         end
         if (cmd_wr && wdata_in[`ISS_CW_KIND] == `ISS_KIND_EOS
             && wdata_in[`ISS_CW_EOS]) begin
            isr_reg <= (isr_reg & ~eos_clr) | (take ? 16'h0001 << pick
                                                   : 16'h0000);
         end else if (take) begin
            isr_reg[pick] <= 1'b1;
         end
      end
   end

   // masks, mode flags and status selection
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         mask_reg <= {`ISS_MASK_RST, `ISS_MASK_RST};
         smm_reg  <= 2'h0;
         ris_reg  <= 2'h0;
         poll_reg <= 2'h0;
      end else begin
         if (wr_in && addr_in == `ISS_A_MASK0) begin
            mask_reg[7:0] <= wdata_in;
         end
         if (wr_in && addr_in == `ISS_A_MASK1) begin
            mask_reg[15:8] <= wdata_in;
         end
         if (cmd_rd) begin
            poll_reg[bank] <= 1'b0;
         end
         if (cmd_wr && wdata_in[`ISS_CW_KIND] == `ISS_KIND_THIRD) begin
            if (wdata_in[`ISS_CW_SET_SPECIAL_MASK_FLAG]) begin
               smm_reg[bank] <= wdata_in[`ISS_CW_SMM];
            end
            if (wdata_in[`ISS_CW_POLL]) begin
               poll_reg[bank] <= 1'b1;
            end else if (wdata_in[`ISS_CW_RR]) begin
               ris_reg[bank] <= wdata_in[`ISS_CW_RIS];
            end
         end
      end
   end

   // route control and serial configuration
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int l = 0; l < 4; l++) begin
            route_reg[l] <= `ISS_RT_RST;
         end
         scfg_reg <= `ISS_SCFG_RST;
      end else if (wr_in) begin
         if (addr_in[3:2] == 2'h1) begin
            route_reg[addr_in[1:0]] <= wdata_in;
         end
         if (addr_in == `ISS_A_SCFG) begin
            scfg_reg <= wdata_in;
         end
      end
   end

   // read multiplexer
   always_comb begin
      rd_mux = 8'h00;
      unique case (addr_in)
         `ISS_A_CMD0, `ISS_A_CMD1: begin
            if (poll_reg[bank]) begin
               rd_mux = {any, 3'h0, pick};
            end else if (ris_reg[bank]) begin
               rd_mux = bank ? isr_reg[15:8] : isr_reg[7:0];
            end else begin
               rd_mux = bank ? irr_reg[15:8] : irr_reg[7:0];
            end
         end
         `ISS_A_MASK0: rd_mux = mask_reg[7:0];
         `ISS_A_MASK1: rd_mux = mask_reg[15:8];
         4'h4, 4'h5, 4'h6, 4'h7: rd_mux = route_reg[addr_in[1:0]];
         `ISS_A_SCFG: rd_mux = scfg_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   // registered processor and software outputs
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_out     <= 8'h00;
         intr_out      <= 1'b0;
         ack_level_out <= `ISS_SPURIOUS;
      end else begin
         rdata_out <= rd_in ? rd_mux : 8'h00;
         intr_out  <= |elig;
         if (inta_in) begin
            ack_level_out <= pick;
         end
      end
   end

   // serial host sequencer
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         hst_reg   <= HS_IDLE;
         cnt_reg   <= `ISS_IDLE_GAP;
         ph_reg    <= 2'h0;
         fr_reg    <= 6'h00;
         quiet_reg <= 1'b0;
         o_reg     <= 1'b1;
         oe_reg    <= 1'b0;
      end else begin
         unique case (hst_reg)
            HS_IDLE: begin
               if (quiet_reg && !sio.line) begin
                  hst_reg <= HS_START;
                  cnt_reg <= {1'b0, slen};
                  o_reg   <= 1'b0;
                  oe_reg  <= 1'b1;
               end else if (!quiet_reg && cnt_reg <= 4'h1) begin
                  hst_reg <= HS_START;
                  cnt_reg <= {1'b0, slen} + 4'h1;
                  o_reg   <= 1'b0;
                  oe_reg  <= 1'b1;
               end else if (!quiet_reg) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            HS_START: begin
               if (cnt_reg <= 4'h1) begin
                  hst_reg <= HS_RISE;
                  o_reg   <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            HS_RISE: begin
               hst_reg <= HS_DATA;
               oe_reg  <= 1'b0;
               ph_reg  <= 2'h1;
               fr_reg  <= 6'h00;
            end
            HS_DATA: begin
               unique case (ph_reg)
                  2'h1: begin
                     if (fr_reg == 6'(NFRAMES)) begin
                        hst_reg <= HS_STOP;
                        o_reg   <= 1'b0;
                        oe_reg  <= 1'b1;
                        cnt_reg <= scfg_reg[`ISS_SCFG_QUIET]
                                   ? `ISS_STOP_QUIET : `ISS_STOP_CONT;
                     end else begin
                        ph_reg <= 2'h2;
                        fr_reg <= fr_reg + 6'h01;
                     end
                  end
                  2'h2: ph_reg <= 2'h0;
                  default: ph_reg <= 2'h1;
               endcase
            end
            HS_STOP: begin
               if (cnt_reg <= 4'h1) begin
                  hst_reg   <= HS_STOPHI;
                  o_reg     <= 1'b1;
                  quiet_reg <= scfg_reg[`ISS_SCFG_QUIET];
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            HS_STOPHI: begin
               hst_reg <= HS_IDLE;
               oe_reg  <= 1'b0;
               cnt_reg <= `ISS_IDLE_GAP;
            end
            default: hst_reg <= HS_IDLE;
         endcase
      end
   end

   // decoded frame levels held until sampled again
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ser_reg <= '0;
      end else if (hst_reg == HS_DATA && ph_reg == 2'h2) begin
         ser_reg[fr_reg] <= ~sio.line;
      end
   end

   // management and channel check outputs
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         external_mgmt_interrupt_out <= 1'b0;
         channel_check_error_out     <= 1'b0;
      end else begin
         external_mgmt_interrupt_out <= ser_reg[`ISS_FR_MGMT];
         channel_check_error_out     <= ser_reg[`ISS_FR_CHK];
      end
   end

   assign sio.host_o  = o_reg;
   assign sio.host_oe = oe_reg;
endmodule

// file: src/iss_periph.sv
// peripheral end of the serial interrupt line
// assumes the host runs the frames on the same clock
`timescale 1ns/10ps
`include "iss_defs.svh"
module iss_periph
   import iss_pkg::*;
#(
   parameter int NFRAMES = `ISS_SIRQ_FRAMES
) (
   // clock and reset
   input  wire logic               clock_in,
   input  wire logic               rst_in,
   // user requests, one level per frame
   input  wire logic [NFRAMES:1]   frame_req_in,
   output logic                    clock_run_req_out,
   // serial interrupt line
   iss_sirq_if.per                 sio
);
   if (NFRAMES < 21 || NFRAMES > 32) begin : g_chk
      $error("NFRAMES must lie in 21..32");
   end

   iss_pst_t          st_reg;
   logic [1:0]        ph_reg;
   logic [5:0]        fr_reg;
   logic [3:0]        lo_reg;
   logic              quiet_reg, o_reg, oe_reg;
   logic [NFRAMES:1]  sent_reg;
   logic              pend;

   assign pend = |(frame_req_in ^ sent_reg);

   // frame follower and sample phase driver
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_reg    <= PS_IDLE;
         ph_reg    <= 2'h0;
         fr_reg    <= 6'h00;
         lo_reg    <= 4'h0;
         quiet_reg <= 1'b0;
         o_reg     <= 1'b1;
         oe_reg    <= 1'b0;
         sent_reg  <= '0;
      end else begin
         unique case (st_reg)
            PS_IDLE: begin
               if (!sio.line) begin
                  st_reg <= PS_WAIT;
               end else if (quiet_reg && pend && clock_run_req_out) begin
                  st_reg <= PS_SELF;
                  o_reg  <= 1'b0;
                  oe_reg <= 1'b1;
               end
            end
            PS_SELF: begin
               st_reg <= PS_WAIT;
               oe_reg <= 1'b0;
            end
            PS_WAIT: begin
               if (sio.line) begin
                  st_reg <= PS_DATA;
                  ph_reg <= 2'h1;
                  fr_reg <= 6'h00;
               end
            end
            PS_DATA: begin
               unique case (ph_reg)
                  2'h1: begin
                     if (fr_reg == 6'(NFRAMES)) begin
                        st_reg <= PS_STOP;
                        lo_reg <= 4'h0;
                     end else begin
                        ph_reg <= 2'h2;
                        fr_reg <= fr_reg + 6'h01;
                        o_reg  <= 1'b0;
                        oe_reg <= frame_req_in[fr_reg + 6'h01];
                        sent_reg[fr_reg + 6'h01] <=
                           frame_req_in[fr_reg + 6'h01];
                     end
                  end
                  2'h2: begin
                     ph_reg <= 2'h0;
                     oe_reg <= 1'b0;
                  end
                  default: ph_reg <= 2'h1;
               endcase
            end
            PS_STOP: begin
               if (!sio.line) begin
                  lo_reg <= lo_reg + 4'h1;
               end else if (lo_reg != 4'h0) begin
                  st_reg    <= PS_IDLE;
                  quiet_reg <= (lo_reg == `ISS_STOP_QUIET);
               end
            end
            default: st_reg <= PS_IDLE;
         endcase
      end
   end

   // clock restart request, raised a clock before the quiet start pulse
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         clock_run_req_out <= 1'b0;
      end else begin
         clock_run_req_out <= quiet_reg && pend
                              && st_reg == PS_IDLE;
      end
   end

   assign sio.per_o  = o_reg;
   assign sio.per_oe = oe_reg;
endmodule

// file: dv/iss_sirq_sva.sv
// checker for the shared serial interrupt line between both ends
// assumes instantiation beside the interface, signals passed by name
`timescale 1ns/10ps
module iss_sirq_sva #(
   parameter int NFRAMES = 21
) (
   // clock and reset
   input  wire logic  clock_in,
   input  wire logic  rst_in,
   // line drives and wired level
   input  wire logic  host_o,
   input  wire logic  host_oe,
   input  wire logic  per_o,
   input  wire logic  per_oe,
   input  wire logic  line
);
   localparam logic [7:0] LAST = 8'(3 * NFRAMES + 1);
   logic       hlo;
   logic       hhi;
   logic       in_data_reg;
   logic       stop_reg;
   logic [7:0] cnt_reg;
   logic [3:0] low_reg;

   // host pulling low or driving high
   assign hlo = host_oe & ~host_o;
   assign hhi = host_oe & host_o;

   // data window: clocks 1 to 3*NFRAMES+1, last turn-around included
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         in_data_reg <= 1'b0;
         stop_reg    <= 1'b0;
         cnt_reg     <= 8'h00;
      end else if (!in_data_reg && hhi) begin
         stop_reg <= 1'b0;
         if (!stop_reg) begin
            in_data_reg <= 1'b1;
            cnt_reg     <= 8'h01;
         end
      end else if (in_data_reg) begin
         cnt_reg     <= cnt_reg + 8'h01;
         in_data_reg <= (cnt_reg != LAST);
         stop_reg    <= (cnt_reg == LAST);
      end
   end

   // consecutive host low clocks
   always_ff @(posedge clock_in) begin
      if (rst_in || !hlo)
         low_reg <= 4'h0;
      else
         low_reg <= low_reg + 4'h1;
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   property p_per_low_only; per_oe |-> !per_o; endproperty
   a_per_low_only: assert property (p_per_low_only)
      else $error("peripheral drove the line high");
   property p_per_pulse; per_oe |=> !per_oe; endproperty
   a_per_pulse: assert property (p_per_pulse)
      else $error("peripheral drove longer than one clock");
   property p_no_clash; !(host_oe && per_oe); endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drove the line together");
   property p_host_high_one; hhi |=> !host_oe; endproperty
   a_host_high_one: assert property (p_host_high_one)
      else $error("host high drive not released after one clock");
   property p_low_bound; hlo |-> low_reg < 4'h8; endproperty
   a_low_bound: assert property (p_low_bound)
      else $error("host held the line low over eight clocks");
   property p_low_end_high; hlo ##1 !hlo |-> hhi; endproperty
   a_low_end_high: assert property (p_low_end_high)
      else $error("host low run not ended by a high clock");
   property p_start_ext; !in_data_reg && per_oe |=> hlo [*3]; endproperty
   a_start_ext: assert property (p_start_ext)
      else $error("host did not extend the peripheral start");
   property p_cont_start; $fell(rst_in) |-> ##[0:6] hlo [*4]; endproperty
   a_cont_start: assert property (p_cont_start)
      else $error("no host start frame after reset");
   property p_sample_slot;
      in_data_reg && per_oe |-> (cnt_reg % 8'h03) == 8'h02;
   endproperty
   a_sample_slot: assert property (p_sample_slot)
      else $error("peripheral drove outside a sample phase");
   property p_quiet_data; in_data_reg |-> !host_oe; endproperty
   a_quiet_data: assert property (p_quiet_data)
      else $error("host drove the line inside data frames");
   property p_stop;
      in_data_reg && cnt_reg == LAST |=>
         hlo [*2] ##1 (hhi or (hlo ##1 hhi));
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop frame not two or three low clocks");
   property p_wire; hlo |-> !line; endproperty
   a_wire: assert property (p_wire)
      else $error("line not low while host pulls it");
endmodule

// file: dv/irq_status_steering_serial_irq_tb.sv
// self-checking bench: host and peripheral ends joined by the line
// assumes design files and the line checker are compiled first
`timescale 1ns/10ps
`define CHECK_EQ(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module irq_status_steering_serial_irq_tb;
   import iss_pkg::*;
   localparam int NF = 21;
   localparam logic [3:0] TGT [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
   logic          clock_in = 1'b0;
   logic          rst_in   = 1'b1;
   logic [3:0]    addr     = 4'h0;
   logic [7:0]    wdata    = 8'h00;
   logic          wr       = 1'b0;
   logic          rd       = 1'b0;
   logic [15:0]   irq      = 16'h0000;
   logic [3:0]    pci_n    = 4'hF;
   logic          inta     = 1'b0;
   logic [NF:1]   freq     = '0;
   logic [7:0]    rdata;
   logic          intr;
   logic [3:0]    ack_lvl;
   logic          mgmt;
   logic          chk;
   logic          crun;
   int            num_errors   = 0;
   int            total_checks = 0;
   int            cycles       = 0;

   iss_sirq_if sio_if ();

   iss_host #(.NFRAMES(NF)) iss_host_i (
      .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .irq_in(irq), .pci_interrupt_line_n_in(pci_n), .inta_in(inta),
      .intr_out(intr), .ack_level_out(ack_lvl),
      .external_mgmt_interrupt_out(mgmt), .channel_check_error_out(chk),
      .sio(sio_if.host));

   iss_periph #(.NFRAMES(NF)) iss_periph_i (
      .clock_in(clock_in), .rst_in(rst_in), .frame_req_in(freq),
      .clock_run_req_out(crun), .sio(sio_if.per));

   iss_sirq_sva #(.NFRAMES(NF)) iss_sirq_sva_i (
      .clock_in(clock_in), .rst_in(rst_in), .host_o(sio_if.host_o),
      .host_oe(sio_if.host_oe), .per_o(sio_if.per_o),
      .per_oe(sio_if.per_oe), .line(sio_if.line));

   // clock and hang guard
   initial forever #10 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   // one-cycle write strobe, then a free cycle
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
      @(posedge clock_in);
   endtask

   // read strobe, data judged in the following cycle
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      `CHECK_EQ(rdata, e)
      @(posedge clock_in);
   endtask

   task automatic t_reset_regs();
      rd_chk(4'h4, 8'h80);
      rd_chk(4'h8, 8'h06);
      rd_chk(4'hF, 8'h00);
      wr_reg(4'h1, 8'hFE);
      rd_chk(4'h1, 8'hFE);
      wr_reg(4'h1, 8'h28);
      irq <= 16'h0028;
      cyc(4);
      rd_chk(4'h0, 8'h28);
      wr_reg(4'h1, 8'h00);
   endtask

   task automatic t_service();
      cyc(3);
      `CHECK_EQ(intr, 1'b1)
      inta <= 1'b1;
      @(posedge clock_in);
      inta <= 1'b0;
      @(posedge clock_in);
      `CHECK_EQ(ack_lvl, 4'h3)
      wr_reg(4'h0, 8'h0B);
      rd_chk(4'h0, 8'h08);
      rd_chk(4'h0, 8'h08);
      `CHECK_EQ(intr, 1'b0)
      wr_reg(4'h0, 8'h68);
      wr_reg(4'h1, 8'h08);
      cyc(3);
      `CHECK_EQ(intr, 1'b1)
      wr_reg(4'h1, 8'h28);
      cyc(3);
      `CHECK_EQ(intr, 1'b0)
      wr_reg(4'h0, 8'h48);
      wr_reg(4'h1, 8'h00);
      cyc(3);
      `CHECK_EQ(intr, 1'b0)
      wr_reg(4'h0, 8'h20);
      wr_reg(4'h0, 8'h0B);
      rd_chk(4'h0, 8'h00);
      wr_reg(4'h0, 8'h0E);
      rd_chk(4'h0, 8'h83);
      wr_reg(4'h0, 8'h20);
      irq <= 16'h0000;
   endtask

   task automatic t_steer();
      logic [3:0] t;
      wr_reg(4'h0, 8'h0A);
      wr_reg(4'h2, 8'h0A);
      pci_n <= 4'hE;
      foreach (TGT[k]) begin
         t = TGT[k];
         wr_reg(4'h4, {4'h0, t});
         cyc(6);
         rd_chk(t[3] ? 4'h2 : 4'h0, 8'h01 << t[2:0]);
      end
      wr_reg(4'h4, 8'h8C);
      cyc(6);
      rd_chk(4'h2, 8'h00);
      pci_n <= 4'hF;
   endtask

   task automatic t_serial();
      wr_reg(4'h8, 8'h0E);
      wr_reg(4'h6, 8'h0A);
      freq <= 21'h090024;
      for (int i = 0; i < 300 && chk !== 1'b1; i++) @(posedge clock_in);
      cyc(100);
      `CHECK_EQ(mgmt, 1'b1)
      `CHECK_EQ(chk, 1'b1)
      rd_chk(4'h0, 8'h20);
      rd_chk(4'h2, 8'h04);
      freq <= '0;
      cyc(200);
      `CHECK_EQ(mgmt, 1'b0)
      wr_reg(4'h8, 8'h07);
      cyc(200);
      freq <= 21'h000004;
      for (int i = 0; i < 20 && crun !== 1'b1; i++) @(posedge clock_in);
      `CHECK_EQ(crun, 1'b1)
      for (int i = 0; i < 300 && mgmt !== 1'b1; i++) @(posedge clock_in);
      `CHECK_EQ(mgmt, 1'b1)
   endtask

   // reset for two clocks, then the scenarios in turn
   initial begin
      cyc(2);
      rst_in <= 1'b0;
      cyc(2);
      t_reset_regs();
      t_service();
      t_steer();
      t_serial();
      finish_test();
   end
endmodule
